// File: rtl/mafe_cfg.svh
// Purpose: Constants for the modem front end serial port block.
// Assumes: pclk serves as the master clock of the front end.
// Notes:   Offsets are byte addresses on the APB bus.
`ifndef MAFE_CFG_SVH
`define MAFE_CFG_SVH
// ============================================================
// Timing
`define MAFE_MCLK_KHZ      9216
`define MAFE_SHIFT_DIV     2'd3
`define MAFE_IN_BITS       5'd16
`define MAFE_RX_FRAME_BITS 5'd13
`define MAFE_TX_FRAME_BITS 5'd24
`define MAFE_ATTEN_MAX     4'he
// ============================================================
// Receive input word fields
`define MAFE_RX_GAIN_LSB   0
`define MAFE_RX_THR_LSB    7
`define MAFE_RX_DPLL_BIT   10
// ============================================================
// Transmit input word fields
`define MAFE_TX_CTRL_BIT   15
`define MAFE_TX_ATTEN_LSB  0
`define MAFE_TX_LPF_LSB    4
`define MAFE_TX_HPF_BIT    6
`define MAFE_TX_NOTCH_BIT  7
`define MAFE_TX_NSEL_BIT   8
`define MAFE_TX_ECHO_BIT   9
// ============================================================
// APB register map and reset values
`define MAFE_ADDR_CTRL     12'h000
`define MAFE_ADDR_STATUS   12'h004
`define MAFE_ADDR_SETTING  12'h008
`define MAFE_CTRL_RESET    1'b1
`define MAFE_THR_SHIFT     9
`endif

// File: rtl/mafe_pkg.sv
// Purpose: Types shared by the modem front end serial port block.
// Assumes: Constants come from mafe_cfg.svh.
// Notes:   Settings travel as one packed struct.
`default_nettype none
package mafe_pkg;
    // ============================================================
    // Settings loaded through the two input ports
    typedef struct packed {
        logic       echo_on;
        logic       notch_sel;
        logic       notch_on;
        logic       hpf_on;
        logic [1:0] lpf_mode;
        logic       dpll_on;
        logic [2:0] threshold;
        logic [3:0] atten;
        logic [6:0] gain;
    } mafe_setting_type;

    typedef struct packed {
        logic enable;
        logic data;
    } mafe_serial_type;

    typedef enum logic [1:0] {
        DAC_IDLE = 2'b00,
        DAC_ECHO = 2'b01,
        DAC_LINE = 2'b10
    } mafe_dac_state_type;
endpackage : mafe_pkg
`default_nettype wire

// File: rtl/mafe_serial_ports.sv
// Purpose: Digital side of a modem analog front end: four serial ports,
//          converter sequencing and the settings loaded by the processor.
// Assumes: pclk is the master clock; all pins synchronous to it.
// Notes:   Overview of operation is listed below.
// Overview of operation
// - Four serial ports, each enable plus data.
// - Receive output enable pulse starts receive shifting.
// - Receive frame: 12 sample bits, then energy bit.
// - Transmit output: echo sample, then hybrid sample.
// - Transmit output enable pulse starts transmit shifting.
// - Converter results are 12-bit two's complement words.
// - Two DAC words per strobe with echo on: echo, then line; one (line) with it off.
// - Echo sampled on transmit strobe, receive on receive.
// - Without echo cancel, bypass summer and reconstruction.
// - Receive gain has 128 steps of 0.375 dB.
// - Transmit attenuator has 15 steps of 1 dB.
// - Energy threshold loaded through receive input port.
// - Filter sections configured through transmit input port.
// - Receive oscillator DPLL mode set via receive port.
// - All timing derived from the single master clock.
// - Shift clock is master clock divided by three.
// - Inputs shift MSB first, 16 bits, extras ignored.
// - Transmit strobe falling edge starts both conversions.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "mafe_cfg.svh"
`default_nettype none
module mafe_serial_ports #(
    parameter int SAMPLE_W = 12,
    parameter int IN_W     = 16
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire mafe_pkg::mafe_serial_type rx_in,
    input  wire mafe_pkg::mafe_serial_type tx_in,
    output mafe_pkg::mafe_serial_type      rx_out,
    output mafe_pkg::mafe_serial_type      tx_out,
    input  wire logic                      tx_sample_strobe,
    input  wire logic                      rx_sample_strobe,
    input  wire logic [SAMPLE_W-1:0]       rx_adc_sample,
    input  wire logic [SAMPLE_W-1:0]       echo_adc_sample,
    input  wire logic [SAMPLE_W-1:0]       hybrid_adc_sample,
    input  wire logic [SAMPLE_W-1:0]       energy_level,
    output logic                           shift_clock,
    output logic                           tx_conv_start,
    output logic                           echo_hold,
    output logic                           rx_conv_start,
    output logic [SAMPLE_W-1:0]            dac_data,
    output logic                           dac_load,
    output logic                           dac_is_echo,
    output logic                           rx_path_bypass,
    output mafe_pkg::mafe_setting_type     setting,
    output logic                           energy_flag
);
    import mafe_pkg::*;

    // Frame layouts below are fixed at 12-bit samples and 16-bit words.
    if (SAMPLE_W != 12 || IN_W != 16) begin : g_bad_size
        $error("mafe_serial_ports serves 12-bit samples, 16-bit words");
    end

    // ============================================================
    // Shift clock from the master clock
    logic [1:0] div_cnt;
    wire        shift_tick = clk_en && (div_cnt == `MAFE_SHIFT_DIV - 2'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt     <= 2'd0;
            shift_clock <= 1'b0;
        end else if (clk_en) begin
            div_cnt     <= shift_tick ? 2'd0 : div_cnt + 2'd1;
            shift_clock <= (div_cnt == 2'd0);
        end
    end

    // ============================================================
    // APB control: bit 0 enables the two serial input ports; the output ports run regardless
    logic ports_on;
    wire  apb_acc   = psel && penable;
    wire  hit_ctrl  = (paddr == `MAFE_ADDR_CTRL);
    wire  hit_stat  = (paddr == `MAFE_ADDR_STATUS);
    wire  hit_set   = (paddr == `MAFE_ADDR_SETTING);
    wire  addr_ok   = hit_ctrl || hit_stat || hit_set;
    mafe_dac_state_type dac_state;
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, ports_on} :
        hit_stat ? {28'h0, dac_state, setting.echo_on, energy_flag} :
        hit_set  ? {11'h0, setting} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = apb_acc && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ports_on <= `MAFE_CTRL_RESET;
            prdata   <= 32'h0;
        end else begin
            if (apb_acc && pwrite && hit_ctrl) begin
                ports_on <= pwdata[0];
            end
            // Captured in the setup cycle so that it stands when pready is
            // sampled in the access cycle; a change in between shows later.
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ============================================================
    // Input ports: index 0 receive, index 1 transmit
    logic [IN_W-1:0] in_shift [2];
    logic [4:0]      in_cnt   [2];
    logic [1:0]      in_prev;
    wire  [1:0]      in_en    = {tx_in.enable, rx_in.enable};
    wire  [1:0]      in_dat   = {tx_in.data, rx_in.data};
    wire  [1:0]      in_done  = {2{shift_tick && ports_on}} & in_prev & ~in_en;

    for (genvar i = 0; i < 2; i++) begin : g_in
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                in_shift[i] <= '0;
                in_cnt[i]   <= 5'd0;
                in_prev[i]  <= 1'b0;
            end else if (shift_tick && ports_on) begin
                in_prev[i] <= in_en[i];
                if (in_en[i] && in_cnt[i] < `MAFE_IN_BITS) begin
                    in_shift[i] <= {in_shift[i][IN_W-2:0], in_dat[i]};
                    in_cnt[i]   <= in_cnt[i] + 5'd1;
                end else if (!in_en[i]) begin
                    in_cnt[i] <= 5'd0;
                end
            end
        end
    end

    // ============================================================
    // Word decode
    wire [IN_W-1:0] rx_word  = in_shift[0];
    wire [IN_W-1:0] tx_word  = in_shift[1];
    wire            tx_ctrl  = tx_word[`MAFE_TX_CTRL_BIT];
    wire [3:0]      atten_in = tx_word[`MAFE_TX_ATTEN_LSB +: 4];
    wire [3:0]      atten_ok = (atten_in > `MAFE_ATTEN_MAX) ?
                               `MAFE_ATTEN_MAX : atten_in;

    // ============================================================
    // Strobe edges
    logic tx_strb_q;
    logic rx_strb_q;
    wire  tx_fall = clk_en && tx_strb_q && !tx_sample_strobe;
    wire  rx_fall = clk_en && rx_strb_q && !rx_sample_strobe;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_strb_q <= 1'b0;
            rx_strb_q <= 1'b0;
        end else if (clk_en) begin
            tx_strb_q <= tx_sample_strobe;
            rx_strb_q <= rx_sample_strobe;
        end
    end

    // ============================================================
    // Settings registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setting <= '0;
        end else if (clk_en) begin
            if (in_done[0]) begin
                setting.gain      <= rx_word[`MAFE_RX_GAIN_LSB +: 7];
                setting.threshold <= rx_word[`MAFE_RX_THR_LSB +: 3];
                setting.dpll_on   <= rx_word[`MAFE_RX_DPLL_BIT];
            end
            if (in_done[1] && tx_ctrl) begin
                setting.atten     <= atten_ok;
                setting.lpf_mode  <= tx_word[`MAFE_TX_LPF_LSB +: 2];
                setting.hpf_on    <= tx_word[`MAFE_TX_HPF_BIT];
                setting.notch_on  <= tx_word[`MAFE_TX_NOTCH_BIT];
                setting.notch_sel <= tx_word[`MAFE_TX_NSEL_BIT];
                setting.echo_on   <= tx_word[`MAFE_TX_ECHO_BIT];
            end
        end
    end

    assign rx_path_bypass = !setting.echo_on;

    // ============================================================
    // Energy detect against the selected threshold
    wire [SAMPLE_W-1:0] thr_level =
        SAMPLE_W'({setting.threshold, 9'h0}) >> (9 - `MAFE_THR_SHIFT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_flag <= 1'b0;
        end else if (clk_en) begin
            energy_flag <= (energy_level > thr_level);
        end
    end

    // ============================================================
    // DAC sequencing: the processor sends two data words per strobe with echo on, one (line) with it off.
    // A data word that arrives with no slot open is dropped, which keeps
    // the echo and line order from slipping after a missed word.
    mafe_dac_state_type next_dac_state;
    wire tx_data_word = in_done[1] && !tx_ctrl;

    always_comb begin
        next_dac_state = dac_state;
        if (tx_fall) begin
            next_dac_state = setting.echo_on ? DAC_ECHO : DAC_LINE;
        end else if (tx_data_word) begin
            case (dac_state)
                DAC_ECHO: next_dac_state = DAC_LINE;
                DAC_LINE: next_dac_state = DAC_IDLE;
                DAC_IDLE: next_dac_state = DAC_IDLE;
                default:  next_dac_state = DAC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_state   <= DAC_IDLE;
            dac_data    <= '0;
            dac_load    <= 1'b0;
            dac_is_echo <= 1'b0;
        end else if (clk_en) begin
            dac_state <= next_dac_state;
            dac_load  <= tx_data_word && !tx_fall && dac_state != DAC_IDLE;
            if (tx_data_word && !tx_fall && dac_state != DAC_IDLE) begin
                dac_data    <= tx_word[SAMPLE_W-1:0];
                dac_is_echo <= (dac_state == DAC_ECHO);
            end
        end
    end

    // ============================================================
    // Conversion starts on the strobe falling edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_conv_start <= 1'b0;
            echo_hold     <= 1'b0;
            rx_conv_start <= 1'b0;
        end else if (clk_en) begin
            tx_conv_start <= tx_fall;
            echo_hold     <= tx_fall && setting.echo_on;
            rx_conv_start <= rx_fall;
        end
    end

    // ============================================================
    // Output ports: index 0 receive, index 1 transmit. Frames are loaded
    // left aligned so one shifter serves both lengths. A new strobe
    // restarts a frame still shifting; the processor must space strobes.
    logic [23:0] out_frame [2];
    logic [4:0]  out_left  [2];
    logic [1:0]  out_en;
    logic [1:0]  out_dat;
    wire  [1:0]  out_load  = {tx_fall, rx_fall};
    wire  [11:0] echo_word = setting.echo_on ? echo_adc_sample : 12'h0;
    wire  [23:0] load_word [2];
    wire  [4:0]  load_len  [2];

    assign load_word[0] = {rx_adc_sample, energy_flag, 11'h0};
    assign load_word[1] = {echo_word, hybrid_adc_sample};
    assign load_len[0]  = `MAFE_RX_FRAME_BITS;
    assign load_len[1]  = `MAFE_TX_FRAME_BITS;

    for (genvar j = 0; j < 2; j++) begin : g_out
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_frame[j] <= '0;
                out_left[j]  <= 5'd0;
                out_en[j]    <= 1'b0;
                out_dat[j]   <= 1'b0;
            end else if (out_load[j]) begin
                out_frame[j] <= load_word[j];
                out_left[j]  <= load_len[j];
            end else if (shift_tick) begin
                if (out_left[j] != 5'd0) begin
                    out_en[j]    <= 1'b1;
                    out_dat[j]   <= out_frame[j][23];
                    out_frame[j] <= {out_frame[j][22:0], 1'b0};
                    out_left[j]  <= out_left[j] - 5'd1;
                end else begin
                    out_en[j]  <= 1'b0;
                    out_dat[j] <= 1'b0;
                end
            end
        end
    end

    assign rx_out = '{enable: out_en[0], data: out_dat[0]};
    assign tx_out = '{enable: out_en[1], data: out_dat[1]};
endmodule : mafe_serial_ports
`default_nettype wire

// File: testbench/mafe_serial_ports_props.sv
// Purpose: Port assertions for mafe_serial_ports.
// Assumes: clk_en stays high in the bench.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module mafe_props #(
    parameter int SAMPLE_W = 12
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       clk_en,
    input wire logic                       tx_sample_strobe,
    input wire logic                       rx_sample_strobe,
    input wire logic [SAMPLE_W-1:0]        energy_level,
    input wire logic                       shift_clock,
    input wire logic                       tx_conv_start,
    input wire logic                       rx_conv_start,
    input wire logic                       echo_hold,
    input wire logic                       rx_path_bypass,
    input wire logic                       energy_flag,
    input wire mafe_pkg::mafe_setting_type setting,
    input wire mafe_pkg::mafe_serial_type  rx_out,
    input wire mafe_pkg::mafe_serial_type  tx_out
);
    import mafe_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ============================================================
    // Frame length in pclk cycles
    logic [6:0] rx_len;
    logic [6:0] tx_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_len <= 7'h00;
            tx_len <= 7'h00;
        end else begin
            rx_len <= rx_out.enable ? rx_len + 7'h01 : 7'h00;
            tx_len <= tx_out.enable ? tx_len + 7'h01 : 7'h00;
        end
    end
    // ============================================================
    // Properties
    property p_bypass;
        rx_path_bypass == !setting.echo_on;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass does not follow echo setting");
    property p_shift;
        shift_clock |=> !shift_clock ##1 !shift_clock ##1 shift_clock;
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift clock is not pclk over three");
    property p_txconv;
        $fell(tx_sample_strobe) && clk_en |=> tx_conv_start;
    endproperty
    a_txconv: assert property (p_txconv)
        else $error("no conversion start after strobe fall");
    property p_rxconv;
        $fell(rx_sample_strobe) && clk_en |=> rx_conv_start;
    endproperty
    a_rxconv: assert property (p_rxconv)
        else $error("no receive conversion start after strobe fall");
    property p_echo;
        $fell(tx_sample_strobe) && setting.echo_on |=> echo_hold;
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo sample not held on strobe");
    property p_rxstart;
        $fell(rx_sample_strobe) && clk_en |-> ##[1:5] rx_out.enable;
    endproperty
    a_rxstart: assert property (p_rxstart)
        else $error("receive frame did not start");
    property p_rxlen;
        $fell(rx_out.enable) |-> rx_len == 7'h27;
    endproperty
    a_rxlen: assert property (p_rxlen)
        else $error("receive frame length wrong");
    property p_txlen;
        $fell(tx_out.enable) |-> tx_len == 7'h48;
    endproperty
    a_txlen: assert property (p_txlen)
        else $error("transmit frame length wrong");
    property p_atten;
        setting.atten != 4'hf;
    endproperty
    a_atten: assert property (p_atten)
        else $error("attenuator beyond last step");
    property p_energy;
        $past(clk_en) |-> energy_flag ==
            ($past(energy_level) > {$past(setting.threshold), 9'h000});
    endproperty
    a_energy: assert property (p_energy)
        else $error("energy flag wrong");
    c_echo: cover property (echo_hold);
    c_rx: cover property ($fell(rx_out.enable));
    c_tx: cover property ($fell(tx_out.enable));
endmodule : mafe_props
`default_nettype wire

// File: testbench/mafe_dsp_model.sv
// Purpose: Processor side of the two serial input ports.
// Assumes: Words are sent one at a time.
// Notes:   The data line toggles for two idle ticks after each word; it has no pull.
`timescale 1ns/1ps
`default_nettype none
module mafe_dsp_model (
    input  wire logic                  pclk,
    input  wire logic                  shift_clock,
    output var mafe_pkg::mafe_serial_type rx_in,
    output var mafe_pkg::mafe_serial_type tx_in
);
    import mafe_pkg::*;
    initial begin
        rx_in = '0;
        tx_in = '0;
    end
    task automatic tick();
        do @(posedge pclk); while (shift_clock !== 1'b1);
    endtask : tick
    // Sends the low n bits of w MSB first, then two idle ticks.
    task automatic send(input logic to_tx, input logic [16:0] w,
                        input int n);
        mafe_serial_type s;
        s = '0;
        tick();
        for (int i = n - 1; i >= -2; i--) begin
            s.enable = (i >= 0);
            s.data = (i >= 0) ? w[i] : ~s.data;
            if (to_tx) tx_in <= s;
            else rx_in <= s;
            tick();
        end
    endtask : send
endmodule : mafe_dsp_model
`default_nettype wire

// File: testbench/mafe_serial_ports_test.sv
// Purpose: Self-checking bench for mafe_serial_ports.
// Assumes: Processor side is mafe_dsp_model.
// Notes:   Random words from a fixed seed.
`timescale 1ns/1ps
`include "mafe_cfg.svh"
`default_nettype none
module mafe_serial_ports_test;
    import mafe_pkg::*;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, rx_adc_sample, echo_adc_sample;
    logic [11:0] hybrid_adc_sample, energy_level, dac_data;
    logic [31:0] pwdata, prdata, rd;
    logic tx_sample_strobe, rx_sample_strobe, shift_clock, echo_hold;
    logic tx_conv_start, rx_conv_start, dac_load, dac_is_echo;
    logic rx_path_bypass, energy_flag, err;
    mafe_serial_type rx_in, tx_in, rx_out, tx_out;
    mafe_setting_type setting, es;
    int n_mismatch, total_checks, cyc, rx_n, tx_n, seed;
    logic [12:0] rx_fr;
    logic [23:0] tx_fr;
    logic [12:0] dq[$];
    logic [15:0] w, d1;
    mafe_serial_ports #(.SAMPLE_W(12), .IN_W(16)) uut (.pclk, .presetn,
        .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_in, .tx_in, .rx_out, .tx_out,
        .tx_sample_strobe, .rx_sample_strobe, .rx_adc_sample,
        .echo_adc_sample, .hybrid_adc_sample, .energy_level, .shift_clock,
        .tx_conv_start, .echo_hold, .rx_conv_start, .dac_data, .dac_load,
        .dac_is_echo, .rx_path_bypass, .setting, .energy_flag);
    mafe_dsp_model dsp (.pclk, .shift_clock, .rx_in, .tx_in);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ============================================================
    // Monitors and timeout
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            n_mismatch++;
            complete_run();
        end
        rx_n <= rx_out.enable ? rx_n + 1 : 0;
        tx_n <= tx_out.enable ? tx_n + 1 : 0;
        if (rx_out.enable && rx_n % 3 == 0) rx_fr <= 13'({rx_fr, rx_out.data});
        if (tx_out.enable && tx_n % 3 == 0) tx_fr <= 24'({tx_fr, tx_out.data});
        if (dac_load === 1'b1) dq.push_back({dac_is_echo, dac_data});
    end
    // ============================================================
    // Tasks
    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // Waits for pready; read data and error are taken at that same edge.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic frames();
        int k;
        k = 0;
        tx_sample_strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        tx_sample_strobe <= 1'b1;
        rx_sample_strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        rx_sample_strobe <= 1'b1;
        while ((rx_out.enable | tx_out.enable) !== 1'b0 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 300) n_mismatch++;
        @(posedge pclk);
    endtask : frames
    function automatic logic eflag(input logic [11:0] lv,
                                   input logic [2:0] t);
        return lv > {t, 9'h000};
    endfunction : eflag
    // ============================================================
    // Main sequence
    initial begin
        seed = $urandom(32'hf9eefd66);
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_adc_sample, echo_adc_sample, hybrid_adc_sample} = '0;
        energy_level = '0;
        {tx_sample_strobe, rx_sample_strobe, clk_en} = 3'h7;
        {n_mismatch, total_checks, cyc, rx_n, tx_n} = '0;
        es = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MAFE_ADDR_CTRL, 32'h0);
        chk(rd, 32'h1, "ctrl reset");
        apb(1'b1, `MAFE_ADDR_SETTING, 32'hffffffff);
        apb(1'b0, `MAFE_ADDR_SETTING, 32'h0);
        chk(rd, 32'h0, "setting read only");
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        for (int i = 0; i < 3; i++) begin
            w = 16'($urandom);
            if (i == 2) dsp.send(1'b0, {w, 1'b1}, 17);
            else dsp.send(1'b0, {1'b0, w}, 16);
            {es.dpll_on, es.threshold, es.gain} = w[10:0];
            chk(32'(setting), 32'(es), "rx word");
        end
        for (int i = 0; i < 4; i++) begin
            w = 16'($urandom) | 16'h8000;
            w[9] = i[0];
            if (i == 2) w[3:0] = 4'hf;
            energy_level <= (i == 1) ? {es.threshold, 9'h000} : 12'($urandom);
            dsp.send(1'b1, {1'b0, w}, 16);
            {es.echo_on, es.notch_sel, es.notch_on} = w[9:7];
            {es.hpf_on, es.lpf_mode, es.atten} = w[6:0];
            if (w[3:0] == 4'hf) es.atten = 4'he;
            chk(32'(setting), 32'(es), "tx word");
            chk(32'(rx_path_bypass), 32'(!w[9]), "bypass");
            apb(1'b0, `MAFE_ADDR_SETTING, 32'h0);
            chk(rd, 32'(es), "setting reg");
            rx_adc_sample     <= 12'($urandom);
            echo_adc_sample   <= 12'($urandom);
            hybrid_adc_sample <= 12'($urandom);
            frames();
            chk(32'(tx_fr), {8'h00, w[9] ? echo_adc_sample : 12'h000,
                hybrid_adc_sample}, "tx frame");
            chk(32'(rx_fr), {19'h0, rx_adc_sample,
                eflag(energy_level, es.threshold)}, "rx frame");
            for (int k = 1; k >= 1 - int'(w[9]); k--) begin
                d1 = 16'($urandom) & 16'h0fff;
                dsp.send(1'b1, {1'b0, d1}, 16);
                chk(32'(dq.size()), 32'h1, "dac count");
                chk(32'(dq.pop_front()), {19'h0, k[0] & w[9],
                    d1[11:0]}, "dac word");
            end
            dsp.send(1'b1, {1'b0, 16'h0123}, 16);
            chk(32'(dq.size()), 32'h0, "idle word dropped");
            apb(1'b0, `MAFE_ADDR_STATUS, 32'h0);
            chk(rd, {28'h0, DAC_IDLE, w[9],
                eflag(energy_level, es.threshold)}, "status");
        end
        complete_run();
    end
endmodule : mafe_serial_ports_test
bind mafe_serial_ports mafe_props #(.SAMPLE_W(SAMPLE_W)) u_props (
    .pclk, .presetn, .clk_en, .tx_sample_strobe, .rx_sample_strobe,
    .energy_level, .shift_clock, .tx_conv_start, .rx_conv_start, .echo_hold,
    .rx_path_bypass, .energy_flag, .setting, .rx_out, .tx_out);
`default_nettype wire
